/* File: hw/eeprom_cmd_pkg.sv */
// constants, opcodes, status layout and state types of the serial eeprom command engine
// assumes a 20 MHz core clock and a host running spi modes 0 or 3 much slower than it
package eeprom_cmd_pkg;

  localparam int CLK_HZ        = 20_000_000;
  localparam int WRITE_TIME_US = 1500;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W       = 20;
  localparam int ADDR_W        = 15;
  localparam int PAGE_W        = 5;
  localparam int PAGE_BYTES    = 1 << PAGE_W;
  localparam int MEM_BYTES     = 1 << ADDR_W;

  // opcodes
  localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
  localparam logic [7:0] OP_WRITE            = 8'h02;
  localparam logic [7:0] OP_READ             = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
  localparam logic [7:0] OP_READ_STATUS      = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] OP_FAST_READ        = 8'h0b;
  localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
  localparam logic [7:0] OP_PAGE_ERASE       = 8'h42;
  localparam logic [7:0] OP_CHIP_ERASE_A     = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B     = 8'hc7;
  localparam logic [7:0] OP_POWER_DOWN       = 8'hb9;

  // status byte 1 field positions
  localparam int SR_WIP        = 0;
  localparam int SR_WEL        = 1;
  localparam int SR_BP_LOW     = 2;
  localparam int SR_BP_HIGH    = 3;
  localparam int SR_LOW_POWER_STANDBY_ENABLE       = 4;
  localparam int SR_AUTO_POWERDOWN_ENABLE       = 5;
  localparam int SR_STATUS_WRITE_DISABLE       = 7;
  localparam logic [7:0] SR1_WRITE_MASK = 8'hbc;
  localparam logic [7:0] SR1_RESET      = 8'h00;

  // status byte 2 field positions
  localparam int SR2_SLOW_OSC  = 0;
  localparam int SR2_AUTO_UDPD = 1;
  localparam logic [7:0] SR2_WRITE_MASK = 8'h03;
  localparam logic [7:0] SR2_RESET      = 8'h00;

  // block protect boundaries
  localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 15'h6000;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE    = 15'h4000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_WDATA,
    ST_STATUS_OUT, ST_STATUS_IN, ST_STATUS2_IN, ST_EXEC, ST_IGNORE
  } state_t;

  typedef enum logic [1:0] {WR_NONE, WR_ARRAY, WR_STATUS1, WR_STATUS2} kind_t;

endpackage

/* File: hw/spi_eeprom_command_engine.sv */
// serial eeprom command engine: opcode decode, reads, page write, status registers
// assumes sck, chip select, serial input and write protect come from outside the core clock
`timescale 1ns/100ps
module spi_eeprom_command_engine
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
  // system
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // spi link
  input  wire logic       sck,
  input  wire logic       chipSelectN,
  input  wire logic       serialIn,
  output logic            serialOut,
  output logic            serialOutEnN,
  // protection and status
  input  wire logic       writeProtectN,
  output logic [7:0]      statusOne,
  output logic [7:0]      statusTwo,
  output logic            writeInProgress
);

  logic [2:0]         sckSync_reg, csSync_reg;
  logic [1:0]         sdiSync_reg, wpSync_reg;
  state_t             state_reg, state_next;
  kind_t              kind_reg, kind_next;
  logic [2:0]         bitCnt_reg, bitCnt_next;
  logic [7:0]         shiftIn_reg, shiftIn_next;
  logic [7:0]         op_reg, op_next;
  logic               addrByte_reg, addrByte_next;
  logic [ADDR_W-1:0]  addr_reg, addr_next;
  logic [7:0]         outShift_reg, outShift_next;
  logic [7:0]         loadByte_reg, loadByte_next;
  logic               loadPend_reg, loadPend_next;
  logic               driveOut_reg, driveOut_next;
  logic               wel_reg, wel_next;
  logic               wip_reg, wip_next;
  logic [7:0]         sr1Nv_reg, sr1Nv_next;
  logic [7:0]         sr2_reg, sr2_next;
  logic [7:0]         pendSr_reg, pendSr_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [PAGE_W-1:0]  pageIdx_reg, pageIdx_next;
  logic [PAGE_BYTES-1:0] pageValid_reg, pageValid_next;
  logic               dataSeen_reg, dataSeen_next;
  logic [7:0]         pageBuf [PAGE_BYTES];
  logic [7:0]         mem [MEM_BYTES];
  logic               sckRise, sckFall, csHigh, csRise, byteDone, srLocked;
  logic               bufWe, memCommit;
  logic [7:0]         byteIn;

  function automatic logic isProtected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    case (bp)
      2'b00:   isProtected = 1'b0;
      2'b01:   isProtected = (a >= PROT_QUARTER_BASE);
      2'b10:   isProtected = (a >= PROT_HALF_BASE);
      default: isProtected = 1'b1;
    endcase
  endfunction

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sckSync_reg <= 3'h0;
      csSync_reg  <= 3'h7;
      sdiSync_reg <= 2'h0;
      wpSync_reg  <= 2'h3;
    end else begin
      sckSync_reg <= {sckSync_reg[1:0], sck};
      csSync_reg  <= {csSync_reg[1:0], chipSelectN};
      sdiSync_reg <= {sdiSync_reg[0], serialIn};
      wpSync_reg  <= {wpSync_reg[0], writeProtectN};
    end
  end

  assign sckRise  = sckSync_reg[1] & ~sckSync_reg[2];
  assign sckFall  = ~sckSync_reg[1] & sckSync_reg[2];
  assign csHigh   = csSync_reg[1];
  assign csRise   = csSync_reg[1] & ~csSync_reg[2];
  assign byteIn   = {shiftIn_reg[6:0], sdiSync_reg[1]};
  assign byteDone = sckRise && !csHigh && bitCnt_reg == 3'd7;
  // lock holds only with pin low
  assign srLocked = sr1Nv_reg[SR_STATUS_WRITE_DISABLE] & ~wpSync_reg[1];

  // busy and latch merged into byte 1
  assign statusOne       = sr1Nv_reg | {6'h00, wel_reg, wip_reg};
  assign statusTwo       = sr2_reg;
  assign writeInProgress = wip_reg;
  assign serialOut       = outShift_reg[7];
  assign serialOutEnN    = ~driveOut_reg;

  always_comb begin
    state_next = state_reg;   kind_next = kind_reg;         bitCnt_next = bitCnt_reg;
    shiftIn_next = shiftIn_reg; op_next = op_reg;           addrByte_next = addrByte_reg;
    addr_next = addr_reg;     outShift_next = outShift_reg; loadByte_next = loadByte_reg;
    loadPend_next = loadPend_reg; driveOut_next = driveOut_reg; wel_next = wel_reg;
    wip_next = wip_reg;       sr1Nv_next = sr1Nv_reg;       sr2_next = sr2_reg;
    pendSr_next = pendSr_reg; timer_next = timer_reg;       pageIdx_next = pageIdx_reg;
    pageValid_next = pageValid_reg; dataSeen_next = dataSeen_reg;
    bufWe = 1'b0;
    memCommit = 1'b0;

    // self-timed cycle end clears busy and latch
    if (wip_reg) begin
      if (timer_reg == '0) begin
        wip_next = 1'b0;
        wel_next = 1'b0;
        kind_next = WR_NONE;
        case (kind_reg)
          // only writable cells take the data
          WR_STATUS1: sr1Nv_next = pendSr_reg & SR1_WRITE_MASK;
          // slow oscillator and auto deep sleep
          WR_STATUS2: sr2_next = pendSr_reg & SR2_WRITE_MASK;
          WR_ARRAY: begin
            memCommit = 1'b1;
            pageValid_next = '0;
          end
          default: ;
        endcase
      end else begin
        timer_next = timer_reg - 1'b1;
      end
    end

    if (csHigh) begin
      state_next = ST_IDLE;
      bitCnt_next = 3'd0;
      driveOut_next = 1'b0;
      loadPend_next = 1'b0;
      if (csRise && bitCnt_reg == 3'd0) begin
        case (state_reg)
          ST_EXEC: begin
            // latch set by its opcode only
            if (op_reg == OP_WRITE_ENABLE) wel_next = 1'b1;
            else wel_next = 1'b0;
          end
          ST_STATUS_IN, ST_STATUS2_IN: begin
            if (dataSeen_reg && (state_reg == ST_STATUS2_IN || !srLocked)) begin
              wip_next = 1'b1;
              timer_next = TIMER_W'(WRITE_CYCLES_P - 1);
              kind_next = (state_reg == ST_STATUS_IN) ? WR_STATUS1 : WR_STATUS2;
            end
          end
          ST_WDATA: begin
            if (dataSeen_reg && !isProtected(sr1Nv_reg[SR_BP_HIGH:SR_BP_LOW], addr_reg)) begin
              wip_next = 1'b1;
              timer_next = TIMER_W'(WRITE_CYCLES_P - 1);
              kind_next = WR_ARRAY;
            end
          end
          default: ;
        endcase
      end
    end else begin
      if (state_reg == ST_IDLE) state_next = ST_OPCODE;
      if (sckRise) begin
        shiftIn_next = byteIn;
        bitCnt_next = bitCnt_reg + 3'd1;
      end
      // data msb first, changes on falling edges
      if (sckFall) begin
        if (loadPend_reg) begin
          outShift_next = loadByte_reg;
          loadPend_next = 1'b0;
        end else begin
          outShift_next = {outShift_reg[6:0], 1'b0};
        end
      end
      if (byteDone) begin
        case (state_reg)
          ST_OPCODE: begin
            op_next = byteIn;
            dataSeen_next = 1'b0;
            addrByte_next = 1'b0;
            if (wip_reg && byteIn != OP_READ_STATUS) state_next = ST_IGNORE;
            else begin
              case (byteIn)
                OP_READ_STATUS: begin
                  state_next = ST_STATUS_OUT;
                  loadByte_next = statusOne;
                  loadPend_next = 1'b1;
                  driveOut_next = 1'b1;
                end
                OP_READ, OP_FAST_READ: state_next = ST_ADDR;
                OP_WRITE: begin
                  state_next = wel_reg ? ST_ADDR : ST_IGNORE;
                  pageValid_next = '0;
                end
                OP_WRITE_STATUS_ONE: state_next = wel_reg ? ST_STATUS_IN : ST_IGNORE;
                OP_WRITE_STATUS_TWO: state_next = wel_reg ? ST_STATUS2_IN : ST_IGNORE;
                OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_PAGE_ERASE,
                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_POWER_DOWN: state_next = ST_EXEC;
                // unknown opcode, rest of frame ignored
                default: state_next = ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addrByte_next = 1'b1;
            if (!addrByte_reg) addr_next[ADDR_W-1:8] = byteIn[6:0];
            else begin
              addr_next[7:0] = byteIn;
              pageIdx_next = byteIn[PAGE_W-1:0];
              // fast read waits one dummy byte
              if (op_reg == OP_FAST_READ) state_next = ST_DUMMY;
              else if (op_reg == OP_READ) begin
                state_next = ST_READ;
                loadByte_next = mem[{addr_reg[ADDR_W-1:8], byteIn}];
                loadPend_next = 1'b1;
                driveOut_next = 1'b1;
              end else state_next = ST_WDATA;
            end
          end
          ST_DUMMY: begin
            state_next = ST_READ;
            loadByte_next = mem[addr_reg];
            loadPend_next = 1'b1;
            driveOut_next = 1'b1;
          end
          // increment with natural wrap to zero
          ST_READ: begin
            addr_next = addr_reg + 15'd1;
            loadByte_next = mem[addr_reg + 15'd1];
            loadPend_next = 1'b1;
          end
          // low bits wrap, later bytes overwrite
          ST_WDATA: begin
            bufWe = 1'b1;
            pageValid_next[pageIdx_reg] = 1'b1;
            pageIdx_next = pageIdx_reg + 5'd1;
            dataSeen_next = 1'b1;
          end
          ST_STATUS_IN, ST_STATUS2_IN: begin
            pendSr_next = byteIn;
            dataSeen_next = 1'b1;
          end
          // polling keeps returning live status
          ST_STATUS_OUT: begin
            loadByte_next = statusOne;
            loadPend_next = 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;     kind_reg <= WR_NONE;     bitCnt_reg <= 3'd0;
      shiftIn_reg <= 8'h00;     op_reg <= 8'h00;         addrByte_reg <= 1'b0;
      addr_reg <= '0;           outShift_reg <= 8'h00;   loadByte_reg <= 8'h00;
      loadPend_reg <= 1'b0;     driveOut_reg <= 1'b0;    wel_reg <= 1'b0;
      wip_reg <= 1'b0;          sr1Nv_reg <= SR1_RESET;  sr2_reg <= SR2_RESET;
      pendSr_reg <= 8'h00;      timer_reg <= '0;         pageIdx_reg <= '0;
      pageValid_reg <= '0;      dataSeen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;  kind_reg <= kind_next;   bitCnt_reg <= bitCnt_next;
      shiftIn_reg <= shiftIn_next; op_reg <= op_next;    addrByte_reg <= addrByte_next;
      addr_reg <= addr_next;    outShift_reg <= outShift_next; loadByte_reg <= loadByte_next;
      loadPend_reg <= loadPend_next; driveOut_reg <= driveOut_next; wel_reg <= wel_next;
      wip_reg <= wip_next;      sr1Nv_reg <= sr1Nv_next; sr2_reg <= sr2_next;
      pendSr_reg <= pendSr_next; timer_reg <= timer_next; pageIdx_reg <= pageIdx_next;
      pageValid_reg <= pageValid_next; dataSeen_reg <= dataSeen_next;
    end
  end

  // array and page buffer carry no reset; only valid bytes reach the array
  always_ff @(posedge core_clk) begin
    if (bufWe) pageBuf[pageIdx_reg] <= byteIn;
    if (memCommit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageValid_reg[i]) mem[{addr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pageBuf[i];
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  welSetCause_a: assert property ($rose(wel_reg) |-> $past(csRise) && $past(op_reg) == OP_WRITE_ENABLE)
    else $error("latch set without write enable");
  welAutoClear_a: assert property ($fell(wip_reg) |-> !wel_reg)
    else $error("latch survived write completion");
  partialFrame_a: assert property (csRise && bitCnt_reg != 3'd0 && !wip_reg |=> wel_reg == $past(wel_reg))
    else $error("partial byte frame changed latch");
  disableAny_a: assert property (csRise && state_reg == ST_EXEC && op_reg == OP_WRITE_DISABLE
                                 && bitCnt_reg == 3'd0 |=> !wel_reg)
    else $error("write disable left latch set");
  statusLoad_a: assert property (byteDone && state_reg == ST_OPCODE && byteIn == OP_READ_STATUS
                                 |=> loadByte_reg == $past(statusOne) && driveOut_reg)
    else $error("status byte not queued for output");
  lockRefuse_a: assert property (csRise && state_reg == ST_STATUS_IN && srLocked && !wip_reg |=> !wip_reg)
    else $error("locked status register accepted a write");
  readWrap_a: assert property (byteDone && state_reg == ST_READ && addr_reg == 15'h7fff |=> addr_reg == 15'h0000)
    else $error("read address did not wrap");
  busyIgnore_a: assert property (byteDone && state_reg == ST_OPCODE && wip_reg && byteIn != OP_READ_STATUS
                                 |=> state_reg == ST_IGNORE)
    else $error("command accepted while busy");
  noLatchWrite_a: assert property (byteDone && state_reg == ST_OPCODE && !wip_reg && !wel_reg
                                   && byteIn == OP_WRITE |=> state_reg == ST_IGNORE)
    else $error("write accepted without latch");

  readData_c: cover property (byteDone && state_reg == ST_READ);
  writeCommit_c: cover property (memCommit);
  statusTwo_c: cover property ($fell(wip_reg) && kind_reg == WR_STATUS2);
endmodule

/* File: tb/spi_host_model.sv */
// spi host model: chip select, mode 0 or mode 3 serial clock and serial input
// assumes the bench calls its tasks; every change lands on a falling core_clk edge
`timescale 1ns/100ps
module spi_host_model (
  // reference clock
  input  wire logic core_clk,
  // spi link
  output logic      sck,
  output logic      chipSelectN,
  output logic      serialIn,
  input  wire logic serialOut
);
  logic cpol = 1'b0;

  initial begin
    sck         = 1'b0;
    chipSelectN = 1'b1;
    serialIn    = 1'b0;
  end

  // 400 ns link period, four core clocks per phase
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  // modes 0 and 3 differ only in the idle level of sck
  task automatic set_mode(input logic m);
    @(negedge core_clk);
    cpol = m;
    sck  = m;
    half();
  endtask

  task automatic select();
    @(negedge core_clk);
    chipSelectN = 1'b0;
    half();
  endtask

  // msb first, input held across the rise
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      if (sck) sck = 1'b0;
      serialIn = tx[i];
      half();
      rx[i] = serialOut;
      sck = 1'b1;
      half();
    end
    // mode 3 leaves sck high between bytes
    if (!cpol) sck = 1'b0;
  endtask

  // release two core clocks after the last bit, with sck low in mode 0 and high in mode 3
  task automatic deselect();
    repeat (2) @(negedge core_clk);
    chipSelectN = 1'b1;
    serialIn    = ~serialIn;
    repeat (12) @(negedge core_clk);
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the serial eeprom command engine
// assumes the host model drives the link; expectations come from a shadow memory
`timescale 1ns/100ps
module tb_top;
  import eeprom_cmd_pkg::*;
  // short write time keeps the run small
  localparam int WCYC = 600;
  logic        core_clk;
  logic        rst_n;
  logic        sck;
  logic        chipSelectN;
  logic        serialIn;
  logic        serialOut;
  logic        serialOutEnN;
  logic        sdoPin;
  logic        writeProtectN;
  logic        writeInProgress;
  logic [7:0]  statusOne;
  logic [7:0]  statusTwo;
  logic [7:0]  rx;
  logic [7:0]  sr1;
  logic [7:0]  sr2;
  logic [7:0]  op;
  logic [14:0] a;
  logic [7:0]  mem [MEM_BYTES];
  logic [14:0] bnd [5] = '{15'h0000, 15'h3fe0, 15'h4000, 15'h5fe0, 15'h6000};
  logic [7:0]  oneOps [4] = '{OP_PAGE_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_POWER_DOWN};
  int          n_fail;
  int          checked;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // released pin shows the opposite of the last bit, no pull-up assumed
  assign sdoPin = serialOutEnN ? ~serialOut : serialOut;

  spi_host_model host (.core_clk(core_clk), .sck(sck), .chipSelectN(chipSelectN),
                       .serialIn(serialIn), .serialOut(sdoPin));

  spi_eeprom_command_engine #(.WRITE_CYCLES_P(WCYC)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .sck(sck), .chipSelectN(chipSelectN),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .writeProtectN(writeProtectN), .statusOne(statusOne), .statusTwo(statusTwo),
    .writeInProgress(writeInProgress));

  function automatic logic prot(input logic [1:0] bp, input logic [14:0] ad);
    case (bp)
      2'b00:   return 1'b0;
      2'b01:   return ad >= PROT_QUARTER_BASE;
      2'b10:   return ad >= PROT_HALF_BASE;
      default: return 1'b1;
    endcase
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_status();
    chk(statusOne, sr1);
    chk(statusTwo, sr2);
  endtask

  task automatic cmd(input logic [7:0] c, input int n);
    host.select();
    host.xfer(c, n, rx);
    host.deselect();
  endtask

  task automatic write_enable_cmd();
    cmd(OP_WRITE_ENABLE, 8);
    sr1[1] = 1'b1;
    chk_status();
  endtask

  // polling is bounded so a stuck busy flag cannot hang the run
  task automatic wait_idle();
    for (int i = 0; i < 4 * WCYC && writeInProgress !== 1'b0; i++) @(negedge core_clk);
    chk({7'h0, writeInProgress}, 8'h00);
    sr1[1:0] = 2'b00;
  endtask

  task automatic addr(input logic [7:0] c, input logic [14:0] ad);
    host.select();
    host.xfer(c, 8, rx);
    host.xfer({1'b0, ad[14:8]}, 8, rx);
    host.xfer(ad[7:0], 8, rx);
  endtask

  task automatic rd(input logic [7:0] c, input logic [14:0] ad, input int n);
    addr(c, ad);
    if (c == OP_FAST_READ) host.xfer(8'($urandom), 8, rx);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'($urandom), 8, rx);
      chk(rx, mem[ad]);
      ad = ad + 15'h0001;
    end
    chk({7'h0, serialOutEnN}, 8'h00);
    host.deselect();
    chk({7'h0, serialOutEnN}, 8'h01);
  endtask

  task automatic wr_page(input logic [14:0] ad, input int n);
    logic       ok;
    logic [7:0] d;
    ok = sr1[1] && !prot(sr1[3:2], ad);
    addr(OP_WRITE, ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host.xfer(d, 8, rx);
      if (ok) mem[{ad[14:5], 5'(ad[4:0] + 5'(i))}] = d;
    end
    host.deselect();
    chk({7'h0, writeInProgress}, {7'h0, ok});
    if (ok) begin
      sr1[0] = 1'b1;
      cmd(OP_WRITE_DISABLE, 8);
      chk_status();
      host.select();
      host.xfer(OP_READ_STATUS, 8, rx);
      host.xfer(8'($urandom), 8, rx);
      chk(rx, sr1);
      host.deselect();
      wait_idle();
      chk_status();
    end
  endtask

  task automatic write_status_one_cmd(input logic [7:0] c, input logic [7:0] d);
    logic ok;
    ok = sr1[1] && (c == OP_WRITE_STATUS_TWO || !(sr1[7] && !writeProtectN));
    host.select();
    host.xfer(c, 8, rx);
    host.xfer(d, 8, rx);
    host.deselect();
    chk({7'h0, writeInProgress}, {7'h0, ok});
    if (ok) begin
      wait_idle();
      if (c == OP_WRITE_STATUS_TWO) sr2 = d & SR2_WRITE_MASK;
      else sr1 = (sr1 & ~SR1_WRITE_MASK) | (d & SR1_WRITE_MASK);
    end
    chk_status();
  endtask

  // expected span is about 44k core clocks
  initial begin
    repeat (95000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    writeProtectN = 1'b1;
    sr1 = SR1_RESET;
    sr2 = SR2_RESET;
    n_fail = 0;
    checked = 0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    void'($urandom(68));
    chk_status();
    wr_page(15'h0010, 3);
    write_enable_cmd();
    cmd(OP_WRITE_DISABLE, 5);
    chk_status();
    writeProtectN = 1'b0;
    cmd(OP_WRITE_DISABLE, 8);
    sr1[1] = 1'b0;
    chk_status();
    writeProtectN = 1'b1;
    write_enable_cmd();
    do op = 8'($urandom);
    while (op inside {OP_WRITE_STATUS_ONE, OP_WRITE, OP_READ, OP_WRITE_DISABLE, OP_READ_STATUS,
      OP_WRITE_ENABLE, OP_FAST_READ, OP_WRITE_STATUS_TWO, OP_PAGE_ERASE, OP_CHIP_ERASE_A,
      OP_CHIP_ERASE_B, OP_POWER_DOWN});
    cmd(op, 8);
    chk_status();
    foreach (oneOps[k]) begin
      write_enable_cmd();
      cmd(oneOps[k], 8);
      sr1[1] = 1'b0;
      chk_status();
    end
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 15'h7fe0 : (k == 1) ? 15'h0000 : 15'($urandom);
      a[4:0] = 5'($urandom);
      write_enable_cmd();
      wr_page(a, (k == 0) ? 40 : 1 + $urandom_range(31));
      rd(OP_READ, {a[14:5], 5'h00}, 32);
    end
    host.set_mode(1'b1);
    rd(OP_FAST_READ, 15'h7ffe, 4);
    rd(OP_READ, 15'h7fff, 2);
    host.set_mode(1'b0);
    for (int bp = 0; bp < 4; bp++) begin
      write_enable_cmd();
      write_status_one_cmd(OP_WRITE_STATUS_ONE, {1'b0, 3'($urandom), 2'(bp), 2'b11});
      foreach (bnd[j]) begin
        write_enable_cmd();
        wr_page(bnd[j], 1);
        rd(OP_READ, bnd[j], 1);
      end
    end
    write_enable_cmd();
    write_status_one_cmd(OP_WRITE_STATUS_ONE, 8'h80);
    writeProtectN = 1'b0;
    write_enable_cmd();
    write_status_one_cmd(OP_WRITE_STATUS_ONE, 8'h00);
    writeProtectN = 1'b1;
    write_status_one_cmd(OP_WRITE_STATUS_ONE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      write_enable_cmd();
      write_status_one_cmd(OP_WRITE_STATUS_TWO, 8'($urandom));
    end
    // second reset with the latch set must clear it again
    write_enable_cmd();
    rst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    sr1 = SR1_RESET;
    sr2 = SR2_RESET;
    chk_status();
    chk({7'h0, serialOutEnN}, 8'h01);
    wrap_up();
  end
endmodule
